// ==== verilog/bcsr_pkg.sv ====
package bcsr_pkg;
  localparam int unsigned BCSR_WIDTH = 8;
  typedef logic [BCSR_WIDTH-1:0] bcsr_data_t;
  typedef logic [7:0] bcsr_addr_t;
  // Decode window for the control register (odd addresses only)
  localparam bcsr_addr_t BCSR_ADDR_LO = 8'hC8;
  localparam bcsr_addr_t BCSR_ADDR_HI = 8'hDF;
  localparam bcsr_data_t BCSR_RESET = 8'h00;
  // Field positions, as in the bit-function list
  localparam int unsigned BIT_GATE0 = 0;
  localparam int unsigned BIT_GATE1 = 1;
  localparam int unsigned BIT_NMI_EN = 2;
  localparam int unsigned BIT_LOCK_BYP = 3;
  localparam int unsigned BIT_IRQ1 = 4;
  localparam int unsigned BIT_IRQ2 = 5;
  localparam int unsigned BIT_LED_B = 6;
  localparam int unsigned BIT_LATCH = 7;
  localparam int unsigned BCSR_RST_STAGES = 2;
endpackage

// ==== verilog/bcsr_top.sv ====
`timescale 1ns/10ps
// Operation
// - Odd I/O writes C8..DF load register
// - Eight register bits drive nine output functions
// - Bit 0 drives timer counter 0 gate
// - Bit 1 drives timer counter 1 gate
// - Bit 2 drives NMI gate enable, high passes NMI
// - Bit 3 drives active-low RAM lock bypass
// - Bit 4 drives first bus interrupt request
// - Bit 5 drives second request and LED A
// - Bit 6 drives LED B only
// - Bit 7 drives latch enable
// - NMI gate bit resets zero, blocking NMI
// - Lock bypass resets zero, bypass asserted
// - High gate enable passes NMI, low blocks
module bcsr_top (
  input wire logic CLK,
  input wire logic RST_B,
  input wire bcsr_pkg::bcsr_addr_t IO_ADDR,
  input wire bcsr_pkg::bcsr_data_t IO_WDATA,
  input wire logic IO_WR,
  input wire logic NMI_IN,
  output logic TIMER0_GATE,
  output logic TIMER1_GATE,
  output logic NMI_GATE_EN_N,
  output logic RAM_LOCK_BYPASS_N,
  output logic SW_BUS_IRQ_FIRST,
  output logic SW_BUS_IRQ_SECOND,
  output logic INDICATOR_LED_A,
  output logic INDICATOR_LED_B,
  output logic LATCH_EN,
  output logic NMI_OUT
);
  import bcsr_pkg::*;

  logic [BCSR_RST_STAGES-1:0] rst_sync;
  logic rst_n;
  logic [2:0] nmi_sync;
  logic nmi_level;
  logic next_nmi_level;
  bcsr_data_t ctrl;
  bcsr_data_t next_ctrl;
  logic next_nmi_out;
  logic hit;

  // Reset release through two flops
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync <= '0;
    end else begin
      rst_sync <= {rst_sync[BCSR_RST_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync[BCSR_RST_STAGES-1];

  // Address decode: odd byte within window
  always_comb begin
    hit = IO_WR && IO_ADDR[0] && (IO_ADDR >= BCSR_ADDR_LO)
          && (IO_ADDR <= BCSR_ADDR_HI);
    next_ctrl = hit ? IO_WDATA : ctrl;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= BCSR_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // NMI pin synchroniser; change taken when stages 2 and 3 agree
  always_comb begin
    next_nmi_level = nmi_level;
    if (nmi_sync[1] == nmi_sync[2]) begin
      next_nmi_level = nmi_sync[2];
    end
    // Gate opens only while the enable bit is one
    next_nmi_out = next_nmi_level && next_ctrl[BIT_NMI_EN];
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      nmi_sync <= '0;
      nmi_level <= 1'b0;
      NMI_OUT <= 1'b0;
    end else begin
      nmi_sync <= {nmi_sync[1:0], NMI_IN};
      nmi_level <= next_nmi_level;
      NMI_OUT <= next_nmi_out;
    end
  end

  // Outputs registered straight from next_ctrl so they track ctrl
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      TIMER0_GATE <= 1'b0;
      TIMER1_GATE <= 1'b0;
      NMI_GATE_EN_N <= 1'b0;
      RAM_LOCK_BYPASS_N <= 1'b0;
      SW_BUS_IRQ_FIRST <= 1'b0;
      SW_BUS_IRQ_SECOND <= 1'b0;
      INDICATOR_LED_A <= 1'b0;
      INDICATOR_LED_B <= 1'b0;
      LATCH_EN <= 1'b0;
    end else begin
      TIMER0_GATE <= next_ctrl[BIT_GATE0];
      TIMER1_GATE <= next_ctrl[BIT_GATE1];
      NMI_GATE_EN_N <= next_ctrl[BIT_NMI_EN];
      RAM_LOCK_BYPASS_N <= next_ctrl[BIT_LOCK_BYP];
      SW_BUS_IRQ_FIRST <= next_ctrl[BIT_IRQ1];
      SW_BUS_IRQ_SECOND <= next_ctrl[BIT_IRQ2];
      INDICATOR_LED_A <= next_ctrl[BIT_IRQ2];
      INDICATOR_LED_B <= next_ctrl[BIT_LED_B];
      LATCH_EN <= next_ctrl[BIT_LATCH];
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence s_write_hit;
    IO_WR && IO_ADDR[0] && IO_ADDR >= BCSR_ADDR_LO
      && IO_ADDR <= BCSR_ADDR_HI;
  endsequence

  sequence s_write_miss;
    IO_WR && !(IO_ADDR[0] && IO_ADDR >= BCSR_ADDR_LO
      && IO_ADDR <= BCSR_ADDR_HI);
  endsequence

  sequence s_no_hit;
    !IO_WR || !IO_ADDR[0] || IO_ADDR < BCSR_ADDR_LO
      || IO_ADDR > BCSR_ADDR_HI;
  endsequence

  // Four samples fill all three synchroniser stages
  sequence s_nmi_high;
    NMI_IN [*4];
  endsequence

  sequence s_nmi_low;
    (!NMI_IN) [*4];
  endsequence

  property p_decode_load;
    s_write_hit |=> ctrl == $past(IO_WDATA);
  endproperty
  a_decode_load: assert property (p_decode_load)
    else $error("decoded write not loaded");

  property p_even_ignored;
    IO_WR && !IO_ADDR[0] |=> ctrl == $past(ctrl);
  endproperty
  a_even_ignored: assert property (p_even_ignored)
    else $error("even address altered register");

  property p_hold;
    !IO_WR |=> $stable(ctrl);
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed without write");

  property p_gate0;
    s_write_hit |=> TIMER0_GATE == $past(IO_WDATA[BIT_GATE0]);
  endproperty
  a_gate0: assert property (p_gate0)
    else $error("timer 0 gate wrong");

  property p_gate1;
    TIMER1_GATE == ctrl[BIT_GATE1];
  endproperty
  a_gate1: assert property (p_gate1)
    else $error("timer 1 gate wrong");

  property p_nmi_en;
    NMI_GATE_EN_N == ctrl[BIT_NMI_EN]
      && RAM_LOCK_BYPASS_N == ctrl[BIT_LOCK_BYP];
  endproperty
  a_nmi_en: assert property (p_nmi_en)
    else $error("NMI enable or bypass wrong");

  property p_irqs;
    SW_BUS_IRQ_FIRST == ctrl[BIT_IRQ1]
      && SW_BUS_IRQ_SECOND == ctrl[BIT_IRQ2]
      && INDICATOR_LED_A == ctrl[BIT_IRQ2];
  endproperty
  a_irqs: assert property (p_irqs)
    else $error("bus request or LED A wrong");

  property p_ledb_latch;
    INDICATOR_LED_B == ctrl[BIT_LED_B] && LATCH_EN == ctrl[BIT_LATCH];
  endproperty
  a_ledb_latch: assert property (p_ledb_latch)
    else $error("LED B or latch wrong");

  property p_nmi_block;
    !ctrl[BIT_NMI_EN] |-> !NMI_OUT;
  endproperty
  a_nmi_block: assert property (p_nmi_block)
    else $error("NMI passed while gate closed");

  property p_miss_ignored;
    s_write_miss |=> $stable(ctrl);
  endproperty
  a_miss_ignored: assert property (p_miss_ignored)
    else $error("missed write altered register");

  // Whole byte lands on the eight outputs in bit order
  property p_all_bits;
    s_write_hit |=> {LATCH_EN, INDICATOR_LED_B, SW_BUS_IRQ_SECOND,
      SW_BUS_IRQ_FIRST, RAM_LOCK_BYPASS_N, NMI_GATE_EN_N, TIMER1_GATE,
      TIMER0_GATE} == $past(IO_WDATA);
  endproperty
  a_all_bits: assert property (p_all_bits)
    else $error("output byte differs from written byte");

  property p_gate1_load;
    s_write_hit |=> TIMER1_GATE == $past(IO_WDATA[BIT_GATE1]);
  endproperty
  a_gate1_load: assert property (p_gate1_load)
    else $error("timer 1 gate not loaded");

  property p_nmi_en_load;
    s_write_hit |=> NMI_GATE_EN_N == $past(IO_WDATA[BIT_NMI_EN]);
  endproperty
  a_nmi_en_load: assert property (p_nmi_en_load)
    else $error("NMI gate enable not loaded");

  property p_bypass_load;
    s_write_hit |=> RAM_LOCK_BYPASS_N == $past(IO_WDATA[BIT_LOCK_BYP]);
  endproperty
  a_bypass_load: assert property (p_bypass_load)
    else $error("lock bypass not loaded");

  property p_irq1_load;
    s_write_hit |=> SW_BUS_IRQ_FIRST == $past(IO_WDATA[BIT_IRQ1]);
  endproperty
  a_irq1_load: assert property (p_irq1_load)
    else $error("first bus request not loaded");

  property p_irq2_load;
    s_write_hit |=> SW_BUS_IRQ_SECOND == $past(IO_WDATA[BIT_IRQ2])
      && INDICATOR_LED_A == $past(IO_WDATA[BIT_IRQ2]);
  endproperty
  a_irq2_load: assert property (p_irq2_load)
    else $error("second bus request or LED A not loaded");

  property p_led_a_pair;
    INDICATOR_LED_A == SW_BUS_IRQ_SECOND;
  endproperty
  a_led_a_pair: assert property (p_led_a_pair)
    else $error("LED A and second request differ");

  property p_ledb_load;
    s_write_hit |=> INDICATOR_LED_B == $past(IO_WDATA[BIT_LED_B]);
  endproperty
  a_ledb_load: assert property (p_ledb_load)
    else $error("LED B not loaded");

  property p_latch_load;
    s_write_hit |=> LATCH_EN == $past(IO_WDATA[BIT_LATCH]);
  endproperty
  a_latch_load: assert property (p_latch_load)
    else $error("latch enable not loaded");

  property p_nmi_closed_start;
    $rose(rst_n) |-> !NMI_GATE_EN_N && !NMI_OUT;
  endproperty
  a_nmi_closed_start: assert property (p_nmi_closed_start)
    else $error("NMI gate open after reset");

  property p_bypass_start;
    $rose(rst_n) |-> !RAM_LOCK_BYPASS_N;
  endproperty
  a_bypass_start: assert property (p_bypass_start)
    else $error("lock bypass released after reset");

  // Outputs keep their value between decoded writes
  property p_out_hold;
    s_no_hit |=> $stable({LATCH_EN, INDICATOR_LED_B, SW_BUS_IRQ_SECOND,
      SW_BUS_IRQ_FIRST, RAM_LOCK_BYPASS_N, NMI_GATE_EN_N, TIMER1_GATE,
      TIMER0_GATE, INDICATOR_LED_A});
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output changed without decoded write");

  // Checked through reset as well, so the default disable is lifted
  property p_reset_zero;
    disable iff (1'h0)
    !rst_n |-> ctrl == BCSR_RESET && !TIMER0_GATE && !TIMER1_GATE
      && !NMI_GATE_EN_N && !RAM_LOCK_BYPASS_N && !SW_BUS_IRQ_FIRST
      && !SW_BUS_IRQ_SECOND && !INDICATOR_LED_A && !INDICATOR_LED_B
      && !LATCH_EN;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("register or output not cleared in reset");

  property p_nmi_pass;
    s_nmi_high |=> NMI_OUT == ctrl[BIT_NMI_EN];
  endproperty
  a_nmi_pass: assert property (p_nmi_pass)
    else $error("settled NMI not passed by open gate");

  property p_nmi_quiet;
    s_nmi_low |=> !NMI_OUT;
  endproperty
  a_nmi_quiet: assert property (p_nmi_quiet)
    else $error("NMI output high with input low");
endmodule

// ==== dv/bcsr_cpu_model.sv ====
`timescale 1ns/10ps
module bcsr_cpu_model (
  input wire logic clk,
  input wire logic go,
  input wire bcsr_pkg::bcsr_addr_t a,
  input wire bcsr_pkg::bcsr_data_t d,
  output bcsr_pkg::bcsr_addr_t io_addr,
  output bcsr_pkg::bcsr_data_t io_wdata,
  output logic io_wr
);
  import bcsr_pkg::*;
  initial begin
    io_addr = 8'h00;
    io_wdata = 8'h00;
    io_wr = 1'b0;
  end
  // One-cycle write; bus shows junk when idle
  always @(posedge clk) begin
    io_wr <= go;
    io_addr <= go ? a : ~io_addr;
    io_wdata <= go ? d : ~io_wdata;
  end
endmodule

// ==== dv/test_board_control_status_register.sv ====
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_board_control_status_register;
  import bcsr_pkg::*;
  logic CLK = 0, RST_B = 0, go = 0, nmi = 0, wr, la, no;
  bcsr_addr_t a = '0, ia;
  bcsr_data_t d = '0, wd, exp = '0;
  wire [BCSR_WIDTH-1:0] o;
  int err_total = 0, check_count = 0, cyc = 0;
  logic [31:0] r = 32'h72b0;
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic hit(bcsr_addr_t x);
    return x[0] && x >= BCSR_ADDR_LO && x <= BCSR_ADDR_HI;
  endfunction
  initial forever #50 CLK = ~CLK;
  bcsr_cpu_model u_cpu (.clk(CLK), .go(go), .a(a), .d(d), .io_addr(ia),
    .io_wdata(wd), .io_wr(wr));
  bcsr_top u_dut (.CLK(CLK), .RST_B(RST_B), .IO_ADDR(ia), .IO_WDATA(wd),
    .IO_WR(wr), .NMI_IN(nmi), .TIMER0_GATE(o[0]), .TIMER1_GATE(o[1]),
    .NMI_GATE_EN_N(o[2]), .RAM_LOCK_BYPASS_N(o[3]),
    .SW_BUS_IRQ_FIRST(o[4]), .SW_BUS_IRQ_SECOND(o[5]),
    .INDICATOR_LED_A(la), .INDICATOR_LED_B(o[6]), .LATCH_EN(o[7]),
    .NMI_OUT(no));
  task stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wr_reg(bcsr_addr_t x, bcsr_data_t y);
    @(posedge CLK);
    go <= 1'b1;
    a <= x;
    d <= y;
    @(posedge CLK);
    go <= 1'b0;
    if (hit(x)) exp = y;
    repeat (2) @(posedge CLK);
    #1;
    `CHK(o, exp)
    `CHK(la, exp[5])
    `CHK(no, nmi & exp[BIT_NMI_EN])
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      stop_test;
    end
  end
  initial begin
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    `CHK({la, o}, 9'h000)
    for (int b = 0; b < 8; b++) wr_reg(8'hC9, 8'h01 << b);
    $display("bit walk done");
    for (int i = 0; i < 256; i++) begin
      r = nx(r);
      wr_reg(i[7:0], r[7:0]);
    end
    $display("address sweep done");
    wr_reg(8'hDF, 8'h14);
    @(posedge CLK) nmi <= 1'b1;
    repeat (5) @(posedge CLK);
    #1;
    `CHK(no, 1'b1)
    wr_reg(8'hC9, 8'h00);
    `CHK(no, 1'b0)
    wr_reg(8'hCB, 8'hFF);
    @(posedge CLK) RST_B <= 1'b0;
    #1;
    `CHK({la, o}, 9'h000)
    $display("nmi and reset done");
    stop_test;
  end
endmodule
